//--- design/tld_defs.vh
// Constants for the thermal limit and turn-on delay register bank.
// Assumes a 100 MHz core clock and 16-bit command words.
`ifndef TLD_DEFS_VH
`define TLD_DEFS_VH

// Command codes (register offsets)
`define TLD_CMD_FAULT_RESP   8'h50
`define TLD_CMD_WARN_THR     8'h51
`define TLD_CMD_TURN_ON_WAIT 8'h60

// Reset values
`define TLD_WARN_THR_RST     8'h64
`define TLD_TURN_ON_WAIT_RST 7'h00
`define TLD_RETRY_RST        3'h7
`define TLD_IGNORE_RST       1'b1

// Field positions in the fault response byte
`define TLD_IGNORE_POS       7
`define TLD_RETRY_MSB        5
`define TLD_RETRY_LSB        3
`define TLD_RESTART_FIXED    3'h7

// Warning threshold limits, in degrees
`define TLD_WARN_MIN         11'h064
`define TLD_WARN_MAX         11'h08C
`define TLD_WARN_BELOW_FAULT 11'h019
`define TLD_WARN_RELEASE     11'h014

// Timing
`define TLD_CLK_NS           10
`define TLD_MS_NS            1000000
`define TLD_SHORT_WAIT_NS    50000
// Cycle counts sized to the 17-bit divider, one ms and 50 us at 10 ns
`define TLD_MS_CYCLES        17'h186A0
`define TLD_SHORT_CYCLES     17'h01388

`endif

//--- design/tld_delay_map.v
// Maps the programmed turn-on wait mantissa to one of sixteen supported delays.
// Pure combinational; the caller registers the result.
`timescale 1ns/100ps
module tld_delay_map (
	input  wire [6:0] mantissa,
	output reg  [6:0] delay_ms,
	output reg        short_wait
);

	// Bucket boundaries; a zero mantissa selects the sub-millisecond wait
	always @* begin
		short_wait = 1'b0;
		if (mantissa == 7'h00) begin
			delay_ms   = 7'h00;
			short_wait = 1'b1;
		end else if (mantissa <= 7'h06) begin
			delay_ms = mantissa;
		end else if (mantissa <= 7'h09) begin
			delay_ms = 7'h07;
		end else if (mantissa <= 7'h0C) begin
			delay_ms = 7'h0A;
		end else if (mantissa <= 7'h11) begin
			delay_ms = 7'h0E;
		end else if (mantissa <= 7'h16) begin
			delay_ms = 7'h13;
		end else if (mantissa <= 7'h20) begin
			delay_ms = 7'h1B;
		end else if (mantissa <= 7'h2C) begin
			delay_ms = 7'h25;
		end else if (mantissa <= 7'h3E) begin
			delay_ms = 7'h34;
		end else if (mantissa <= 7'h56) begin
			delay_ms = 7'h48;
		end else begin
			delay_ms = 7'h64;
		end
	end

endmodule // tld_delay_map

//--- design/tld_regs.v
// Thermal limit supervision and turn-on delay register bank.
// Assumes a command port driven by a bus front end on sys_clk, temperature
// samples and fault levels from on-chip logic, and a start pin from outside.
// Function
// - Retry field zero: stay off after thermal fault until faults are cleared.
// - Retry field all ones (default): restart soft-start endlessly until off or other fault.
// - Retry write other than 000/111 rejected, sets CML, invalid data, alert.
// - Only retry bit five goes to nonvolatile memory; restore copies it thrice.
// - Internal thermal faults follow retry but are never ignored; restart after cooling.
// - Temperature above warning threshold sets temperature, warning flags and alert.
// - Warning stays latched until temperature falls twenty degrees below threshold.
// - Warning threshold write at or above fault threshold flags CML, invalid data, alert.
// - Default warning threshold is fault threshold minus 25, at least 100.
// - Warning threshold exponent reads zero; only low eight mantissa bits writable.
// - Warning mantissa defaults to 100, accepts 100 through 140.
// - Turn-on wait sets milliseconds from start to ramp; stored by store-all.
// - Turn-on wait exponent zero, upper mantissa bits zero, low seven writable.
// - Only sixteen turn-on delays exist, selected by mantissa buckets.
// - Mantissa zero gives 50 us, then table buckets up to 100 ms.
// - Ignore-select one: shut down on external fault, restart per retry field.
// - Low three fault response bits read ones: restart after seven ramp times.
`timescale 1ns/100ps
`include "tld_defs.vh"
module tld_regs #(
	parameter [16:0] MS_CYCLES    = `TLD_MS_CYCLES,
	parameter [16:0] SHORT_CYCLES = `TLD_SHORT_CYCLES
) (
	input  wire        sys_clk,
	input  wire        arst_n,
	input  wire        reg_wr,
	input  wire        reg_rd,
	input  wire [7:0]  reg_cmd,
	input  wire [15:0] reg_wdata,
	output reg  [15:0] reg_rdata_r,
	input  wire [10:0] thermal_fault_level,
	input  wire        temp_valid,
	input  wire [10:0] temp_sample,
	input  wire        ext_fault,
	input  wire        int_fault,
	input  wire        die_cool,
	input  wire        clear_faults,
	input  wire        start_pin,
	input  wire [6:0]  ramp_ms,
	input  wire        nvm_restore,
	input  wire        nvm_retry_bit,
	input  wire        nvm_ignore_bit,
	input  wire [6:0]  nvm_wait_mant,
	input  wire        store_all,
	output reg         nvm_store_r,
	output reg         nvm_retry_out_r,
	output reg         nvm_ignore_out_r,
	output reg  [6:0]  nvm_wait_out_r,
	output reg         status_byte_cml_r,
	output reg         status_cml_ivd_r,
	output reg         status_byte_temp_r,
	output reg         status_temp_warn_r,
	output reg         thermal_warn_level_r,
	output reg         smbalert_n_r,
	output reg         ramp_enable_r,
	output reg         fault_latched_r
);

	// State codes, one-hot
	localparam [4:0] ST_OFF   = 5'h01;
	localparam [4:0] ST_WAIT  = 5'h02;
	localparam [4:0] ST_ON    = 5'h04;
	localparam [4:0] ST_RETRY = 5'h08;
	localparam [4:0] ST_HOLD  = 5'h10;

	// Reset release through two flops; async assert, sync release
	reg        rst_s1_r;
	reg        rst_n_r;
	always @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			rst_s1_r <= 1'b0;
			rst_n_r  <= 1'b0;
		end else begin
			rst_s1_r <= 1'b1;
			rst_n_r  <= rst_s1_r;
		end
	end

	// Start pin: three flops, a change counts once stages two and three agree
	reg        start_s1_r;
	reg        start_s2_r;
	reg        start_s3_r;
	reg        start_r;
	always @(posedge sys_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			start_s1_r <= 1'b0;
			start_s2_r <= 1'b0;
			start_s3_r <= 1'b0;
			start_r    <= 1'b0;
		end else begin
			start_s1_r <= start_pin;
			start_s2_r <= start_s1_r;
			start_s3_r <= start_s2_r;
			if (start_s2_r == start_s3_r) begin
				start_r <= start_s3_r;
			end
		end
	end

	// Configuration storage
	reg  [2:0]  retry_r;
	reg         ignore_r;
	reg  [7:0]  warn_thr_r;
	reg  [6:0]  wait_mant_r;

	// Write decode and validation
	wire        wr_resp   = reg_wr && (reg_cmd == `TLD_CMD_FAULT_RESP);
	wire        wr_warn   = reg_wr && (reg_cmd == `TLD_CMD_WARN_THR);
	wire        wr_wait   = reg_wr && (reg_cmd == `TLD_CMD_TURN_ON_WAIT);
	wire [2:0]  wr_retry  = reg_wdata[`TLD_RETRY_MSB:`TLD_RETRY_LSB];
	wire        retry_ok  = (wr_retry == 3'h0) || (wr_retry == 3'h7);
	wire [10:0] wr_thr    = {3'h0, reg_wdata[7:0]};
	wire        thr_range = (wr_thr >= `TLD_WARN_MIN) && (wr_thr <= `TLD_WARN_MAX);
	wire        thr_order = wr_thr < thermal_fault_level;
	wire        bad_resp  = wr_resp && !retry_ok;
	wire        bad_warn  = wr_warn && !(thr_range && thr_order);
	wire        cmd_error = bad_resp || bad_warn;

	// Default warning threshold derived from the fault threshold, floored
	wire [10:0] fault_less = thermal_fault_level - `TLD_WARN_BELOW_FAULT;
	wire        fault_low  = thermal_fault_level < (`TLD_WARN_MIN + `TLD_WARN_BELOW_FAULT);
	wire [10:0] warn_dflt  = fault_low ? `TLD_WARN_MIN : fault_less;

	// Register updates; restore from memory has priority over a host write
	always @(posedge sys_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			retry_r     <= `TLD_RETRY_RST;
			ignore_r    <= `TLD_IGNORE_RST;
			warn_thr_r  <= `TLD_WARN_THR_RST;
			wait_mant_r <= `TLD_TURN_ON_WAIT_RST;
		end else if (nvm_restore) begin
			retry_r     <= {3{nvm_retry_bit}};
			ignore_r    <= nvm_ignore_bit;
			warn_thr_r  <= warn_dflt[7:0];
			wait_mant_r <= nvm_wait_mant;
		end else begin
			if (wr_resp && retry_ok) begin
				retry_r  <= wr_retry;
				ignore_r <= reg_wdata[`TLD_IGNORE_POS];
			end
			if (wr_warn && thr_range && thr_order) begin
				warn_thr_r <= reg_wdata[7:0];
			end
			if (wr_wait) begin
				wait_mant_r <= reg_wdata[6:0];
			end
		end
	end

	// Store-all snapshot; memory keeps one retry bit since all three agree
	always @(posedge sys_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			nvm_store_r      <= 1'b0;
			nvm_retry_out_r  <= 1'b1;
			nvm_ignore_out_r <= 1'b1;
			nvm_wait_out_r   <= 7'h00;
		end else begin
			nvm_store_r <= store_all;
			if (store_all) begin
				nvm_retry_out_r  <= retry_r[`TLD_RETRY_MSB - `TLD_RETRY_LSB];
				nvm_ignore_out_r <= ignore_r;
				nvm_wait_out_r   <= wait_mant_r;
			end
		end
	end

	// Read mux, registered; unmapped codes read zero
	reg  [15:0] rd_nxt;
	always @* begin
		case (reg_cmd)
			`TLD_CMD_FAULT_RESP:   rd_nxt = {8'h00, ignore_r, 1'b0, retry_r,
			                                 `TLD_RESTART_FIXED};
			`TLD_CMD_WARN_THR:     rd_nxt = {8'h00, warn_thr_r};
			`TLD_CMD_TURN_ON_WAIT: rd_nxt = {9'h000, wait_mant_r};
			default:               rd_nxt = 16'h0000;
		endcase
	end

	always @(posedge sys_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			reg_rdata_r <= 16'h0000;
		end else if (reg_rd) begin
			reg_rdata_r <= rd_nxt;
		end
	end

	// Warning hysteresis, evaluated only on fresh samples
	wire [10:0] thr_wide   = {3'h0, warn_thr_r};
	wire        warn_trip  = temp_sample > thr_wide;
	wire        warn_clear = (temp_sample + `TLD_WARN_RELEASE) <= thr_wide;
	always @(posedge sys_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			thermal_warn_level_r <= 1'b0;
		end else if (temp_valid) begin
			if (warn_trip) begin
				thermal_warn_level_r <= 1'b1;
			end else if (warn_clear) begin
				thermal_warn_level_r <= 1'b0;
			end
		end
	end

	// Sticky status; a new event beats a clear in the same cycle
	wire        warn_event = temp_valid && warn_trip;
	always @(posedge sys_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			status_byte_cml_r  <= 1'b0;
			status_cml_ivd_r   <= 1'b0;
			status_byte_temp_r <= 1'b0;
			status_temp_warn_r <= 1'b0;
		end else begin
			if (cmd_error) begin
				status_byte_cml_r <= 1'b1;
				status_cml_ivd_r  <= 1'b1;
			end else if (clear_faults) begin
				status_byte_cml_r <= 1'b0;
				status_cml_ivd_r  <= 1'b0;
			end
			// Warning bits cannot clear while the latched level is still up
			if (warn_event) begin
				status_byte_temp_r <= 1'b1;
				status_temp_warn_r <= 1'b1;
			end else if (clear_faults && !thermal_warn_level_r) begin
				status_byte_temp_r <= 1'b0;
				status_temp_warn_r <= 1'b0;
			end
		end
	end

	// Alert follows any pending status, one cycle behind the flags
	always @(posedge sys_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			smbalert_n_r <= 1'b1;
		end else begin
			smbalert_n_r <= !(status_byte_cml_r || status_byte_temp_r);
		end
	end

	// Supported delay for the current mantissa
	wire [6:0]  map_ms;
	wire        map_short;
	tld_delay_map u_map (
		.mantissa   (wait_mant_r),
		.delay_ms   (map_ms),
		.short_wait (map_short)
	);

	// Millisecond tick divider, restarted when a wait is loaded
	reg  [16:0] div_r;
	reg         tick_r;
	reg         div_clr;
	always @(posedge sys_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			div_r  <= 17'h00000;
			tick_r <= 1'b0;
		end else if (div_clr) begin
			div_r  <= 17'h00000;
			tick_r <= 1'b0;
		end else if (div_r == MS_CYCLES - 17'h00001) begin
			div_r  <= 17'h00000;
			tick_r <= 1'b1;
		end else begin
			div_r  <= div_r + 17'h00001;
			tick_r <= 1'b0;
		end
	end

	// Sequencer
	reg  [4:0]  state_r;
	reg  [4:0]  state_nxt;
	reg  [9:0]  ms_cnt_r;
	reg  [9:0]  ms_cnt_nxt;
	reg         short_r;
	reg         short_nxt;
	reg         int_seen_r;
	reg         int_seen_nxt;

	// Faults that force shutdown; internal ones are never ignored
	wire        ext_trip  = ext_fault && ignore_r;
	wire        any_trip  = ext_trip || int_fault;
	wire        retry_on  = (retry_r == 3'h7);
	wire [9:0]  restart_ms = {3'h0, ramp_ms} * {7'h00, `TLD_RESTART_FIXED};
	wire        wait_done = short_r ? (div_r == SHORT_CYCLES - 17'h00001)
	                                : (tick_r && ms_cnt_r <= 10'h001);

	always @* begin
		state_nxt    = state_r;
		ms_cnt_nxt   = ms_cnt_r;
		short_nxt    = short_r;
		int_seen_nxt = int_seen_r;
		div_clr      = 1'b0;
		if (tick_r && ms_cnt_r != 10'h000) begin
			ms_cnt_nxt = ms_cnt_r - 10'h001;
		end
		case (state_r)
			ST_OFF: begin
				if (start_r) begin
					state_nxt  = ST_WAIT;
					ms_cnt_nxt = {3'h0, map_ms};
					short_nxt  = map_short;
					div_clr    = 1'b1;
				end
			end
			ST_WAIT: begin
				if (!start_r) begin
					state_nxt = ST_OFF;
				end else if (wait_done) begin
					state_nxt = ST_ON;
				end
			end
			ST_ON: begin
				if (!start_r) begin
					state_nxt = ST_OFF;
				end else if (any_trip) begin
					int_seen_nxt = int_fault;
					if (retry_on) begin
						state_nxt  = ST_RETRY;
						ms_cnt_nxt = restart_ms;
						short_nxt  = 1'b0;
						div_clr    = 1'b1;
					end else begin
						state_nxt = ST_HOLD;
					end
				end
			end
			ST_RETRY: begin
				// Internal faults also wait for the die to cool
				if (!start_r) begin
					state_nxt = ST_OFF;
				end else if (ms_cnt_r == 10'h000 && (!int_seen_r || die_cool)) begin
					state_nxt  = ST_WAIT;
					ms_cnt_nxt = {3'h0, map_ms};
					short_nxt  = map_short;
					div_clr    = 1'b1;
				end
			end
			ST_HOLD: begin
				// Latched off; only a clear or a fresh off command frees it
				if (clear_faults || !start_r) begin
					state_nxt = ST_OFF;
				end
			end
			default: begin
				state_nxt = ST_OFF;
			end
		endcase
	end

	always @(posedge sys_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			state_r    <= ST_OFF;
			ms_cnt_r   <= 10'h000;
			short_r    <= 1'b0;
			int_seen_r <= 1'b0;
		end else begin
			state_r    <= state_nxt;
			ms_cnt_r   <= ms_cnt_nxt;
			short_r    <= short_nxt;
			int_seen_r <= int_seen_nxt;
		end
	end

	// Outputs from flops, one cycle after the state
	always @(posedge sys_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			ramp_enable_r   <= 1'b0;
			fault_latched_r <= 1'b0;
		end else begin
			ramp_enable_r   <= (state_r == ST_ON);
			fault_latched_r <= (state_r == ST_HOLD);
		end
	end

endmodule // tld_regs

//--- test/tld_regs_properties.sv
// Port checker for the thermal limit and turn-on delay bank.
// Sees only tld_regs ports; bound at the foot of this file.
`timescale 1ns/100ps
module tld_regs_properties (
	input wire        sys_clk,
	input wire        arst_n,
	input wire        reg_wr,
	input wire [7:0]  reg_cmd,
	input wire [15:0] reg_wdata,
	input wire [10:0] thermal_fault_level,
	input wire        temp_valid,
	input wire        start_pin,
	input wire        store_all,
	input wire        nvm_store_r,
	input wire        status_byte_cml_r,
	input wire        status_cml_ivd_r,
	input wire        status_byte_temp_r,
	input wire        status_temp_warn_r,
	input wire        thermal_warn_level_r,
	input wire        smbalert_n_r,
	input wire        ramp_enable_r,
	input wire        fault_latched_r
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!arst_n);
	// Writes that must be refused
	wire bad_retry = reg_wr && reg_cmd == 8'h50 && reg_wdata[5:3] != 3'h0
		&& reg_wdata[5:3] != 3'h7;
	wire bad_wt = reg_wr && reg_cmd == 8'h51 && ({3'h0, reg_wdata[7:0]} >= thermal_fault_level
		|| reg_wdata[7:0] < 8'h64 || reg_wdata[7:0] > 8'h8C);
	// Flag, alert, ramp and store relations
	chk_retry_reject: assert property (bad_retry |=> status_byte_cml_r && status_cml_ivd_r)
		else $error("bad retry write not flagged");
	chk_warn_reject: assert property (bad_wt |=> status_byte_cml_r && status_cml_ivd_r)
		else $error("bad threshold write not flagged");
	chk_alert_low: assert property (status_byte_cml_r || status_byte_temp_r |=> !smbalert_n_r)
		else $error("alert not raised");
	chk_warn_sets: assert property ($rose(thermal_warn_level_r) |->
		status_byte_temp_r && status_temp_warn_r)
		else $error("warning flags missing");
	chk_warn_sticky: assert property (thermal_warn_level_r |-> status_temp_warn_r)
		else $error("warning flag dropped");
	chk_warn_sample: assert property ($changed(thermal_warn_level_r) |-> $past(temp_valid))
		else $error("warning moved without sample");
	chk_latched_off: assert property (fault_latched_r |-> !ramp_enable_r)
		else $error("ramp while latched off");
	chk_store_pulse: assert property (store_all |=> nvm_store_r)
		else $error("store not issued");
	chk_start_first: assert property ($rose(ramp_enable_r) |-> $past(start_pin, 4))
		else $error("ramp without start");
	cover property (bad_retry);
	cover property ($rose(thermal_warn_level_r));
	cover property ($rose(ramp_enable_r));
	cover property ($rose(fault_latched_r));
endmodule // tld_regs_properties
bind tld_regs tld_regs_properties chk_u (.*);

//--- test/tld_host_model.sv
// Host on the command port: one-cycle strobes.
// Drives at falling edges; idle data lines show inverted stale values.
`timescale 1ns/100ps
module tld_host_model (
	input  wire        sys_clk,
	input  wire [15:0] reg_rdata_r,
	output reg         reg_wr,
	output reg         reg_rd,
	output reg  [7:0]  reg_cmd,
	output reg  [15:0] reg_wdata
);
	// Idle levels at time zero
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_cmd = 8'h00;
		reg_wdata = 16'h0000;
	end
	// Write: strobe held across one rising edge
	task wr(input [7:0] c, input [15:0] d);
		begin
			@(negedge sys_clk);
			reg_cmd = c;
			reg_wdata = d;
			reg_wr = 1'b1;
			@(negedge sys_clk);
			reg_wr = 1'b0;
			reg_wdata = ~d; // Stale data must not pass as valid
		end
	endtask
	// Read: data registered at the edge that takes the strobe
	task rd(input [7:0] c, output [15:0] d);
		begin
			@(negedge sys_clk);
			reg_cmd = c;
			reg_rd = 1'b1;
			@(negedge sys_clk);
			reg_rd = 1'b0;
			d = reg_rdata_r;
		end
	endtask
endmodule // tld_host_model

//--- test/tld_regs_tb_top.sv
// Bench for tld_regs with host model and checker.
// Assumes shortened counts: 20 cycles per ms, 5 for the short wait.
`timescale 1ns/100ps
module tld_regs_tb_top;
	localparam [16:0] MC = 17'h00014;
	localparam [16:0] SC = 17'h00005;
	localparam [63:0] UB = 64'h563E2C2016110C09;
	localparam [63:0] MS = 64'h4834251B130E0A07;
	localparam [63:0] ML = 64'h5756_0A09_0706_0100;
	reg         sys_clk = 1'b0, arst_n = 1'b0, temp_valid = 1'b0, ext_fault = 1'b0;
	reg         int_fault = 1'b0, die_cool = 1'b1, clear_faults = 1'b0, start_pin = 1'b0;
	reg         nvm_restore = 1'b0, nvm_retry_bit = 1'b0, nvm_ignore_bit = 1'b1, store_all = 1'b0;
	reg  [10:0] thermal_fault_level = 11'h07D, temp_sample = 11'h000;
	reg  [6:0]  ramp_ms = 7'h01, nvm_wait_mant = 7'h05;
	wire        reg_wr, reg_rd, nvm_store_r, nvm_retry_out_r, nvm_ignore_out_r, fault_latched_r;
	wire        status_byte_cml_r, status_cml_ivd_r, status_byte_temp_r, status_temp_warn_r;
	wire        thermal_warn_level_r, smbalert_n_r, ramp_enable_r;
	wire [7:0]  reg_cmd;
	wire [15:0] reg_wdata, reg_rdata_r;
	wire [6:0]  nvm_wait_out_r;
	integer     fails = 0, n_checks = 0, seed = 12, i, cnt, ok;
	reg  [15:0] w, e;
	tld_regs #(.MS_CYCLES(MC), .SHORT_CYCLES(SC)) dut_u (.*);
	tld_host_model host_u (.*);
	always #5 sys_clk = ~sys_clk;
	task chk(input [15:0] g, input [15:0] x);
		begin
			n_checks = n_checks + 1;
			if (g !== x) begin
				fails = fails + 1;
				$display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
			end
		end
	endtask
	task rc(input [7:0] c, input [15:0] x);
		begin
			host_u.rd(c, w);
			chk(w, x);
		end
	endtask
	task clr;
		begin
			clear_faults = 1'b1;
			@(negedge sys_clk) clear_faults = 1'b0;
			@(negedge sys_clk);
		end
	endtask
	// Bounded wait for the ramp enable, cycles kept in cnt
	task wramp(input x);
		begin
			cnt = 0;
			while (ramp_enable_r !== x && cnt < 4000) begin
				@(negedge sys_clk);
				cnt = cnt + 1;
			end
			chk(ramp_enable_r, x);
		end
	endtask
	// Expected start-to-ramp cycles for a mantissa
	function integer dly(input integer m);
		integer k;
		begin
			dly = 100;
			for (k = 7; k >= 0; k = k - 1)
				if (m <= UB[k*8+:8]) dly = MS[k*8+:8];
			if (m <= 6) dly = m;
			dly = (m == 0) ? SC : dly * MC;
		end
	endfunction
	task ton(input [6:0] m);
		begin
			w = $random(seed);
			host_u.wr(8'h60, {w[15:7], m});
			rc(8'h60, {9'h000, m});
			start_pin = 1'b1;
			wramp(1'b1);
			chk(cnt >= dly(m) && cnt <= dly(m) + 12, 1);
			start_pin = 1'b0;
			repeat (8) @(negedge sys_clk);
		end
	endtask
	task smp(input [10:0] t, input x);
		begin
			temp_sample = t;
			temp_valid = 1'b1;
			@(negedge sys_clk) temp_valid = 1'b0;
			temp_sample = ~t; // Stale sample must not count
			@(negedge sys_clk);
			chk(thermal_warn_level_r, x);
		end
	endtask
	task give_verdict;
		begin
			$display("checks=%0d fails=%0d", n_checks, fails);
			if (fails == 0 && n_checks > 0)
				$display("Run complete: PASS");
			else
				$display("Run complete: FAIL");
			$finish;
		end
	endtask
	// Watchdog: far beyond the longest expected run
	initial begin
		#600000;
		fails = fails + 1;
		give_verdict;
	end
	// Main sequence
	initial begin
		repeat (6) @(negedge sys_clk);
		arst_n = 1'b1;
		repeat (3) @(negedge sys_clk);
		rc(8'h50, 16'h00BF);
		rc(8'h51, 16'h0064);
		rc(8'h60, 16'h0000);
		rc(8'h33, 16'h0000);
		for (i = 0; i < 8; i = i + 1) begin
			host_u.wr(8'h50, {8'h00, 2'b10, i[2:0], 3'h0});
			ok = (i == 0 || i == 7);
			e = ok ? {8'h00, 2'b10, {3{i[0]}}, 3'h7} : 16'h0087;
			rc(8'h50, e);
			chk({status_byte_cml_r, status_cml_ivd_r, smbalert_n_r}, ok ? 3'h1 : 3'h6);
			clr;
		end
		e = 16'h0064 + {$random(seed)} % 25;
		host_u.wr(8'h51, {$random(seed)} & 16'hFF00 | e);
		for (i = 0; i < 4; i = i + 1) begin
			rc(8'h51, e);
			chk(status_cml_ivd_r, i > 0);
			clr;
			host_u.wr(8'h51, {8'hA5, i[1:0] == 0 ? 8'h63 : i[1:0] == 1 ? 8'h8D : 8'h7D});
		end
		clr;
		host_u.wr(8'h51, 16'h006E);
		for (i = 0; i < 4; i = i + 1)
			smp(i == 0 ? 11'h06E : i == 1 ? 11'h06F : i == 2 ? 11'h05B : 11'h05A, i == 1 || i == 2);
		chk({status_byte_temp_r, status_temp_warn_r, smbalert_n_r}, 3'h6);
		clr;
		chk(smbalert_n_r, 1);
		for (i = 0; i < 10; i = i + 1)
			ton(i < 8 ? ML[i*8+:8] : $random(seed));
		host_u.wr(8'h60, 16'h0000);
		host_u.wr(8'h50, 16'h0087);
		start_pin = 1'b1;
		wramp(1'b1);
		ext_fault = 1'b1;
		repeat (4) @(negedge sys_clk);
		ext_fault = 1'b0;
		repeat (300) @(negedge sys_clk);
		chk({fault_latched_r, ramp_enable_r}, 2'h2);
		clr;
		chk(fault_latched_r, 0);
		start_pin = 1'b0;
		host_u.wr(8'h50, 16'h003F);
		start_pin = 1'b1;
		wramp(1'b1);
		ext_fault = 1'b1;
		repeat (300) @(negedge sys_clk);
		ext_fault = 1'b0;
		chk(ramp_enable_r, 1);
		int_fault = 1'b1;
		die_cool = 1'b0;
		repeat (10) @(negedge sys_clk);
		int_fault = 1'b0;
		chk(ramp_enable_r, 0);
		repeat (300) @(negedge sys_clk);
		chk(ramp_enable_r, 0);
		die_cool = 1'b1;
		wramp(1'b1);
		start_pin = 1'b0;
		clr;
		for (i = 0; i < 2; i = i + 1) begin
			thermal_fault_level = i ? 11'h078 : 11'h08C;
			nvm_restore = 1'b1;
			@(negedge sys_clk) nvm_restore = 1'b0;
			rc(8'h51, i ? 16'h0064 : 16'h0073);
		end
		rc(8'h50, 16'h0087);
		rc(8'h60, 16'h0005);
		store_all = 1'b1;
		@(negedge sys_clk) store_all = 1'b0;
		chk({nvm_store_r, nvm_retry_out_r, nvm_ignore_out_r, nvm_wait_out_r}, 10'h285);
		give_verdict;
	end
endmodule // tld_regs_tb_top
